// file: rtc_consts.svh
// register offsets, field positions and reset values of the rf test bank
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define RTC_OFS_AMP_LEVEL 8'he2
`define RTC_OFS_PRESCALER 8'he6
`define RTC_OFS_DELAY 8'he9
`define RTC_OFS_SYNTH 8'hec
`define RTC_OFS_FRONT_END 8'hee
`define RTC_OFS_TEST_SEL 8'hef
`define RTC_OFS_RESERVED_BIT1_FIRST 8'hf1
`define RTC_OFS_RESERVED_BIT1_LAST 8'hf7
`define RTC_RST_AMP_LEVEL 8'h0f
`define RTC_RST_PRESCALER 8'h00
`define RTC_RST_DELAY 8'h2f
`define RTC_RST_SYNTH 5'h01
`define RTC_RST_FRONT_END 8'h00
`define RTC_RST_TEST_SEL 4'h0
`define RTC_RST_RESERVED_BIT1 5'h00
`define RTC_SYNTH_W 5
`define RTC_RESERVED_BIT1_W 5
`define RTC_SEL_W 4
`define RTC_BIT_DIV_RST_N 0
`define RTC_BIT_LOOP_FILT 4
`define RTC_BIT_IF_FRONT 2
`define RTC_BIT_IF_INPUT 3
`define RTC_BIT_SIG_EN 1
`define RTC_BIT_IF_EXT 2
`define RTC_SWING_HI 7
`define RTC_SWING_LO 6
`define RTC_CURR_HI 5
`define RTC_CURR_LO 4
`define RTC_SEL_OFF 4'h0
`define RTC_RD_ZERO 8'h00
`endif

// file: rtc_pkg.sv
// types shared by the rf test control register bank
package rtc_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rtc_bus_req_t;

    typedef enum logic [1:0] {
        RTC_SWING_X1 = 2'h0,
        RTC_SWING_X2_3 = 2'h1,
        RTC_SWING_X7_3 = 2'h2,
        RTC_SWING_X5_3 = 2'h3
    } rtc_swing_t;

    typedef enum logic [1:0] {
        RTC_CURR_X1 = 2'h0,
        RTC_CURR_X2_3 = 2'h1,
        RTC_CURR_X1_2 = 2'h2,
        RTC_CURR_X2_5 = 2'h3
    } rtc_curr_t;

    typedef struct packed {
        logic [3:0] high_array_level;
        logic [3:0] low_array_level;
        rtc_swing_t swing;
        rtc_curr_t current;
        logic if_input;
        logic if_front;
        logic divider_reset_n;
        logic loop_filter_select;
        logic signal_strength_enable;
        logic if_external;
        logic [7:0] shaping_delay;
    } rtc_analog_ctl_t;

    // three pins of port 0, index 0 is pin 0
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe_n;
    } rtc_port_t;
endpackage

// file: rtc_regs.sv
// rf test control register bank with test multiplexer onto port 0
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "rtc_consts.svh"

module rtc_regs #(
    parameter int RESERVED_BIT1_REGS = 7
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire rtc_pkg::rtc_bus_req_t bus_req,
    output logic [7:0] rd_data,
    // normal port value and direction, direction 1 means output
    input wire logic [2:0] port0_out_value,
    input wire logic [2:0] port0_direction,
    // internal test sources
    input wire logic clk_ref,
    input wire logic clk_phase_det,
    input wire logic modem_tx_out,
    input wire logic lock_det_continuous,
    input wire logic lock_det_instant,
    input wire logic analog_window_sync,
    input wire logic ser_par_irq,
    input wire logic timer2_irq,
    input wire logic timer3_irq,
    input wire logic rtc_irq,
    input wire logic adc_irq,
    input wire logic cipher_irq,
    input wire logic analog_alarm_high,
    input wire logic analog_alarm_low,
    input wire logic cal_complete,
    input wire logic modem_bit_clk,
    input wire logic modem_rx_data,
    input wire logic analog_if_out,
    input wire logic modem_tx_data,
    input wire logic adc_clk_en,
    input wire logic analog_comp,
    input wire logic adc_end_of_conv,
    input wire logic clk_rtc,
    input wire logic clk_micro,
    input wire logic [3:0] cipher_debug,
    input wire logic flash_write_irq,
    output rtc_pkg::rtc_analog_ctl_t analog_ctl,
    output logic signal_strength_to_pin,
    output rtc_pkg::rtc_port_t port0_pins
);
    initial begin
        if (RESERVED_BIT1_REGS != 7) begin
            $error("rtc_regs: shaping bank is fixed at seven registers");
        end
    end

    logic [7:0] amp_level_q;
    logic [7:0] prescaler_q;
    logic [7:0] delay_q;
    logic [`RTC_SYNTH_W-1:0] synth_q;
    logic [7:0] front_end_q;
    logic [`RTC_SEL_W-1:0] test_sel_q;
    logic [`RTC_RESERVED_BIT1_W-1:0] reserved_bit1_q [RESERVED_BIT1_REGS];
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic [2:0] test_val;
    logic [2:0] test_used;
    logic sig_pin_q;
    rtc_pkg::rtc_port_t port_q;
    rtc_pkg::rtc_port_t port_d;

    wire logic wr = bus_req.wr;
    wire logic [7:0] wa = bus_req.addr;
    wire logic [7:0] reserved_bit1_idx = wa - `RTC_OFS_RESERVED_BIT1_FIRST;
    wire logic reserved_bit1_hit = (wa >= `RTC_OFS_RESERVED_BIT1_FIRST) &&
        (wa <= `RTC_OFS_RESERVED_BIT1_LAST);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            amp_level_q <= `RTC_RST_AMP_LEVEL;
        end else if (wr && wa == `RTC_OFS_AMP_LEVEL) begin
            amp_level_q <= bus_req.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prescaler_q <= `RTC_RST_PRESCALER;
        end else if (wr && wa == `RTC_OFS_PRESCALER) begin
            // reserved low bits are kept as written so they read back
            prescaler_q <= bus_req.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            delay_q <= `RTC_RST_DELAY;
        end else if (wr && wa == `RTC_OFS_DELAY) begin
            delay_q <= bus_req.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            synth_q <= `RTC_RST_SYNTH;
        end else if (wr && wa == `RTC_OFS_SYNTH) begin
            synth_q <= bus_req.wdata[`RTC_SYNTH_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            front_end_q <= `RTC_RST_FRONT_END;
        end else if (wr && wa == `RTC_OFS_FRONT_END) begin
            front_end_q <= bus_req.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            test_sel_q <= `RTC_RST_TEST_SEL;
        end else if (wr && wa == `RTC_OFS_TEST_SEL) begin
            test_sel_q <= bus_req.wdata[`RTC_SEL_W-1:0];
        end
    end

    // reset value is undefined by design; zero chosen so sims stay clean
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < RESERVED_BIT1_REGS; i++) begin
                reserved_bit1_q[i] <= `RTC_RST_RESERVED_BIT1;
            end
        end else if (wr && reserved_bit1_hit) begin
            reserved_bit1_q[reserved_bit1_idx[2:0]] <=
                bus_req.wdata[`RTC_RESERVED_BIT1_W-1:0];
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_data_d = `RTC_RD_ZERO;
        if (reserved_bit1_hit) begin
            rd_data_d = {3'h0, reserved_bit1_q[reserved_bit1_idx[2:0]]};
        end else begin
            case (wa)
                `RTC_OFS_AMP_LEVEL: rd_data_d = amp_level_q;
                `RTC_OFS_PRESCALER: rd_data_d = prescaler_q;
                `RTC_OFS_DELAY: rd_data_d = delay_q;
                `RTC_OFS_SYNTH: rd_data_d = {3'h0, synth_q};
                `RTC_OFS_FRONT_END: rd_data_d = front_end_q;
                `RTC_OFS_TEST_SEL: rd_data_d = {4'h0, test_sel_q};
                default: rd_data_d = `RTC_RD_ZERO;
            endcase
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_q <= `RTC_RD_ZERO;
        end else if (bus_req.rd) begin
            rd_data_q <= rd_data_d;
        end else begin
            rd_data_q <= `RTC_RD_ZERO;
        end
    end
    assign rd_data = rd_data_q;

    // fixed triple per select code; slot 0 is pin 2
    always_comb begin
        test_val = 3'h0;
        test_used = 3'h7;
        case (test_sel_q)
            4'h1: test_val = {clk_ref, clk_phase_det, modem_tx_out};
            4'h2: test_val = {lock_det_continuous, lock_det_instant,
                              analog_window_sync};
            4'h3: test_val = {ser_par_irq, timer2_irq, timer3_irq};
            4'h4: test_val = {rtc_irq, adc_irq, cipher_irq};
            4'h5: test_val = {analog_alarm_high, analog_alarm_low,
                              cal_complete};
            4'h6: test_val = {modem_bit_clk, modem_rx_data, analog_if_out};
            4'h7: test_val = {modem_bit_clk, modem_tx_data, modem_tx_out};
            4'h8: test_val = {adc_clk_en, analog_comp, adc_end_of_conv};
            4'h9: test_val = {clk_rtc, rtc_irq, clk_micro};
            4'ha: test_val = {cipher_debug[0], 2'h0};
            4'hb: test_val = {cipher_debug[1], 2'h0};
            4'hc: test_val = {cipher_debug[2], 2'h0};
            4'hd: test_val = {cipher_debug[3], 2'h0};
            4'he: test_val = {flash_write_irq, 2'h0};
            4'hf: test_val = {cal_complete, 2'h0};
            default: test_used = 3'h0;
        endcase
        // codes from 0xa leave pins 1 and 0 on their normal value
        if (test_sel_q >= 4'ha) begin
            test_used = 3'h4;
        end
    end

    always_comb begin
        for (int p = 0; p < 3; p++) begin
            // test value only replaces pins configured as outputs
            port_d.out[p] = (test_used[p] && port0_direction[p]) ?
                test_val[p] : port0_out_value[p];
            port_d.oe_n[p] = !port0_direction[p];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_q <= '{out: 3'h0, oe_n: 3'h7};
        end else begin
            port_q <= port_d;
        end
    end
    assign port0_pins = port_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sig_pin_q <= 1'b0;
        end else begin
            sig_pin_q <= front_end_q[`RTC_BIT_SIG_EN];
        end
    end
    assign signal_strength_to_pin = sig_pin_q;

    // analog controls are static settings and leave straight from flops
    always_comb begin
        analog_ctl.high_array_level = amp_level_q[7:4];
        analog_ctl.low_array_level = amp_level_q[3:0];
        analog_ctl.swing = rtc_pkg::rtc_swing_t'(
            prescaler_q[`RTC_SWING_HI:`RTC_SWING_LO]);
        analog_ctl.current = rtc_pkg::rtc_curr_t'(
            prescaler_q[`RTC_CURR_HI:`RTC_CURR_LO]);
        analog_ctl.if_input = prescaler_q[`RTC_BIT_IF_INPUT];
        analog_ctl.if_front = prescaler_q[`RTC_BIT_IF_FRONT];
        analog_ctl.divider_reset_n = synth_q[`RTC_BIT_DIV_RST_N];
        analog_ctl.loop_filter_select = synth_q[`RTC_BIT_LOOP_FILT];
        analog_ctl.signal_strength_enable = front_end_q[`RTC_BIT_SIG_EN];
        analog_ctl.if_external = front_end_q[`RTC_BIT_IF_EXT];
        analog_ctl.shaping_delay = delay_q;
    end
endmodule

// file: rtc_regs_sva.sv
// concurrent checks for the rf test control register bank
`timescale 1ns/1ps
module rtc_regs_sva (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire rtc_pkg::rtc_bus_req_t bus_req,
    input wire logic [7:0] rd_data,
    input wire logic [2:0] port0_out_value,
    input wire rtc_pkg::rtc_analog_ctl_t analog_ctl,
    input wire logic signal_strength_to_pin,
    input wire rtc_pkg::rtc_port_t port0_pins
);
    logic [3:0] sel_q;
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    assign w = bus_req.wr;
    assign a = bus_req.addr;
    assign d = bus_req.wdata;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // shadow of the select code so the pin check knows which pins are muxed
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_q <= 4'h0;
        end else if (w && a == 8'hef) begin
            sel_q <= d[3:0];
        end
    end
    property p_amp;
        w && a == 8'he2 |=> {analog_ctl.high_array_level,
            analog_ctl.low_array_level} == $past(d);
    endproperty
    a_amp: assert property (p_amp) else $error("amp level lost");
    property p_dly;
        w && a == 8'he9 |=> analog_ctl.shaping_delay == $past(d);
    endproperty
    a_dly: assert property (p_dly) else $error("delay lost");
    property p_syn;
        w && a == 8'hec |=> analog_ctl.divider_reset_n == $past(d[0])
            && analog_ctl.loop_filter_select == $past(d[4]);
    endproperty
    a_syn: assert property (p_syn) else $error("synth lost");
    property p_pre;
        w && a == 8'he6 |=> {analog_ctl.swing, analog_ctl.current,
            analog_ctl.if_input, analog_ctl.if_front} == $past(d[7:2]);
    endproperty
    a_pre: assert property (p_pre) else $error("prescaler lost");
    property p_shp;
        bus_req.rd && a > 8'hf0 && a < 8'hf8 |=> rd_data[7:5] == 3'h0;
    endproperty
    a_shp: assert property (p_shp) else $error("reserved_bit1 top bits set");
    property p_tsel;
        bus_req.rd && a == 8'hef |=> rd_data[7:4] == 4'h0;
    endproperty
    a_tsel: assert property (p_tsel) else $error("select top bits");
    property p_norm;
        sel_q == 4'h0 || sel_q > 4'h9 |=>
            port0_pins.out[1:0] == $past(port0_out_value[1:0]);
    endproperty
    a_norm: assert property (p_norm) else $error("pins not normal");
    property p_sig;
        1'b1 |=> signal_strength_to_pin
            == $past(analog_ctl.signal_strength_enable);
    endproperty
    a_sig: assert property (p_sig) else $error("strength pin wrong");
    cover property (w && a == 8'hef && d[3:0] != 4'h0);
    cover property (sel_q == 4'hf);
    cover property (bus_req.rd && a == 8'hec);
endmodule
bind rtc_regs rtc_regs_sva rtc_regs_sva_i (.core_clk(core_clk),
    .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
    .port0_out_value(port0_out_value), .analog_ctl(analog_ctl),
    .signal_strength_to_pin(signal_strength_to_pin),
    .port0_pins(port0_pins));

// file: rtc_regs_tb.sv
// self-checking bench for the rf test control register bank
`timescale 1ns/1ps
module rtc_regs_tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    rtc_pkg::rtc_bus_req_t bus_req = '0;
    logic [7:0] rd_data;
    logic [2:0] pv = 3'h0;
    logic [2:0] pd = 3'h0;
    logic [28:0] s = '0;
    rtc_pkg::rtc_analog_ctl_t analog_ctl;
    logic sig_pin;
    rtc_pkg::rtc_port_t port0_pins;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    int mismatches = 0;
    int checks_done = 0;
    rtc_regs rtc_regs_i (.core_clk(core_clk), .rst_b(rst_b),
        .bus_req(bus_req), .rd_data(rd_data), .port0_out_value(pv),
        .port0_direction(pd), .clk_ref(s[0]), .clk_phase_det(s[1]),
        .modem_tx_out(s[2]), .lock_det_continuous(s[3]),
        .lock_det_instant(s[4]), .analog_window_sync(s[5]),
        .ser_par_irq(s[6]), .timer2_irq(s[7]), .timer3_irq(s[8]),
        .rtc_irq(s[9]), .adc_irq(s[10]), .cipher_irq(s[11]),
        .analog_alarm_high(s[12]), .analog_alarm_low(s[13]),
        .cal_complete(s[14]), .modem_bit_clk(s[15]), .modem_rx_data(s[16]),
        .analog_if_out(s[17]), .modem_tx_data(s[18]), .adc_clk_en(s[19]),
        .analog_comp(s[20]), .adc_end_of_conv(s[21]), .clk_rtc(s[22]),
        .clk_micro(s[23]), .cipher_debug(s[27:24]), .flash_write_irq(s[28]),
        .analog_ctl(analog_ctl), .signal_strength_to_pin(sig_pin),
        .port0_pins(port0_pins));
    always #12.5 core_clk = ~core_clk;
    task automatic final_report;
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input string n, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic [7:0] a, d, input logic w, r);
        @(posedge core_clk);
        bus_req <= '{a, d, w, r};
    endtask
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        bus(a, 8'h00, 1'b0, 1'b1);
    endtask
    // pin triple per select code as indices into s, -1 keeps the normal value
    function automatic logic [7:0] exp_pins(input logic [3:0] c);
        int p [3];
        logic [2:0] o;
        o = pv;
        case (c)
            4'h0: p = '{-1, -1, -1};
            4'h1: p = '{0, 1, 2};
            4'h2: p = '{3, 4, 5};
            4'h3: p = '{6, 7, 8};
            4'h4: p = '{9, 10, 11};
            4'h5: p = '{12, 13, 14};
            4'h6: p = '{15, 16, 17};
            4'h7: p = '{15, 18, 2};
            4'h8: p = '{19, 20, 21};
            4'h9: p = '{22, 9, 23};
            4'he: p = '{28, -1, -1};
            4'hf: p = '{14, -1, -1};
            default: p = '{int'(c) + 14, -1, -1};
        endcase
        for (int k = 0; k < 3; k++) begin
            if (p[2 - k] >= 0 && pd[k]) begin
                o[k] = s[p[2 - k]];
            end
        end
        return {2'b00, o, ~pd};
    endfunction
    always @(posedge core_clk) begin
        if (rd_seen) begin
            cmp("read", exp_q.pop_front(), rd_data);
        end
        rd_seen = bus_req.rd;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        final_report();
    end
    initial begin
        logic [7:0] wv [32];
        logic [7:0] a;
        void'($urandom(75));
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            a = 8'he0 + i[7:0];
            rd(a, a == 8'he2 ? 8'h0f : a == 8'he9 ? 8'h2f :
                a == 8'hec ? 8'h01 : 8'h00);
        end
        repeat (2) begin
            for (int i = 0; i < 32; i++) begin
                a = 8'he0 + i[7:0];
                // reserved synth and prescaler bits are kept at zero
                wv[i] = 8'($urandom()) & (a == 8'hec ? 8'h11 :
                    a == 8'he6 ? 8'hfc : 8'hff);
                bus(a, wv[i], 1'b1, 1'b0);
            end
            for (int i = 0; i < 32; i++) begin
                a = 8'he0 + i[7:0];
                rd(a, wv[i] & (a == 8'hef ? 8'h0f : (a > 8'hf0 &&
                    a < 8'hf8) ? 8'h1f : (a == 8'he2 || a == 8'he6 ||
                    a == 8'he9 || a == 8'hec || a == 8'hee) ? 8'hff : 8'h00));
            end
        end
        for (int c = 0; c < 16; c++) begin
            bus(8'hef, 8'(c), 1'b1, 1'b0);
            bus(8'h00, 8'h00, 1'b0, 1'b0);
            repeat (4) begin
                @(posedge core_clk);
                s <= 29'($urandom());
                pv <= 3'($urandom());
                pd <= 3'($urandom());
                @(posedge core_clk);
                #1 cmp("pins", exp_pins(4'(c)), {2'b00, port0_pins});
            end
        end
        // firmware returns the test settings to their normal state
        bus(8'he6, 8'h00, 1'b1, 1'b0);
        bus(8'hef, 8'h00, 1'b1, 1'b0);
        bus(8'he2, 8'h00, 1'b1, 1'b0);
        rd(8'he6, 8'h00);
        rd(8'he2, 8'h00);
        // the converter is outside this bank; only the enable is here
        bus(8'hee, 8'h02, 1'b1, 1'b0);
        bus(8'h00, 8'h00, 1'b0, 1'b0);
        repeat (3) @(posedge core_clk);
        final_report();
    end
endmodule
